// File: tes_pkg.sv
// Shared constants, types and helpers of the trigger and exposure sequencer.
package tes_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 100;
	localparam int TD_NS         = 6100;
	localparam int ITF_NS        = 4950;
	localparam int TE_MIN_NS     = 10000;
	localparam int TE_MAX_NS     = 98050000;
	localparam int TD_CYC        = (TD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ITF_CYC       = (ITF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TE_MIN_CYC    = (TE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
	localparam int RD_MIN_CYC    = 1;
	localparam int CW            = 20;
	localparam int EXP_W         = 17;
	localparam int NUM_ENT       = 10;
	localparam int IDX_W         = 4;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_ACQ     = 8'h04;
	localparam logic [7:0] OFS_EXP1    = 8'h08;
	localparam logic [7:0] OFS_EXP2    = 8'h0c;
	localparam logic [7:0] OFS_RDLEN   = 8'h10;
	localparam logic [7:0] OFS_REP     = 8'h14;
	localparam logic [7:0] OFS_SEL     = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1c;
	localparam logic [7:0] OFS_ENT_ROI = 8'h20;
	localparam logic [7:0] OFS_ENT_OFS = 8'h24;
	localparam logic [7:0] OFS_ENT_CFG = 8'h28;
	localparam logic [7:0] OFS_ENT_EXP = 8'h2c;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PIV      = 2;
	localparam int CTRL_OVL      = 3;
	localparam int CTRL_BIN      = 4;
	localparam int CTRL_SRST     = 5;
	localparam int ACQ_MULTI     = 0;
	localparam int ACQ_CNT_LSB   = 8;
	localparam int STAT_IDX_LSB  = 4;
	localparam int STAT_FC_LSB   = 8;
	localparam int STAT_REP_LSB  = 16;
	localparam int STAT_DONE     = 24;
	localparam int STAT_RD       = 25;

	localparam logic [1:0]    FLD_ROI     = 2'h0;
	localparam logic [1:0]    FLD_OFS     = 2'h1;
	localparam logic [1:0]    FLD_CFG     = 2'h2;
	localparam logic [1:0]    FLD_EXP     = 2'h3;
	localparam logic [7:0]    PIV_FRAMES  = 8'h02;
	localparam logic [7:0]    ACQ_CNT_RST = 8'h01;
	localparam logic [7:0]    REP_RST     = 8'h01;
	localparam logic [CW-1:0] EXP1_RST    = 20'h003e8;
	localparam logic [CW-1:0] EXP2_RST    = 20'h003e8;
	localparam logic [CW-1:0] RDLEN_RST   = 20'h003e8;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		VM_NORMAL = 2'b00,
		VM_SEQ    = 2'b01,
		VM_MULTI  = 2'b10
	} tes_vmode_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DELAY   = 4'b0001,
		ST_EXP1    = 4'b0010,
		ST_GAP     = 4'b0011,
		ST_EXP2    = 4'b0100,
		ST_WAIT_RD = 4'b0101,
		ST_EXP     = 4'b0110
	} tes_state_t;

	typedef struct packed {
		logic [15:0]      width;
		logic [15:0]      height;
		logic [15:0]      x;
		logic [15:0]      y;
		logic [15:0]      gain;
		logic [EXP_W-1:0] exp_us;
		logic [7:0]       fcount;
		logic [IDX_W-1:0] next;
	} tes_entry_t;

	typedef struct packed {
		logic [15:0] width;
		logic [15:0] height;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] gain;
	} tes_frame_t;

	localparam tes_entry_t ENT_RST = '{width: 16'h0ce0, height: 16'h09a8, x: 16'h0010,
		y: 16'h0004, gain: 16'h0000, exp_us: 17'h17ed0, fcount: 8'h01, next: 4'h0};
	localparam tes_frame_t FRAME_DEF = '{width: 16'h0ce0, height: 16'h09a8, x: 16'h0010,
		y: 16'h0004, gain: 16'h0000};

	function automatic logic [CW-1:0] tes_clamp(input int unsigned v, input int unsigned lo,
		input int unsigned hi);
		int unsigned r;
		r = (v < lo) ? lo : ((v > hi) ? hi : v);
		return r[CW-1:0];
	endfunction : tes_clamp

endpackage : tes_pkg

// File: tes_trig_sync.sv
// Two-stage synchroniser and rising-edge detector for the trigger pin.
`timescale 1ns/1ps
module tes_trig_sync (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic pin,
	output wire logic rise
);
	import tes_pkg::*;

	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else if (ce) begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign rise = s2_r && !s3_r;

endmodule : tes_trig_sync

// File: tes_entry_table.sv
// Table of sequence entries with write port, binning halving and two read ports.
`timescale 1ns/1ps
module tes_entry_table (
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	input  wire logic                     ce,
	input  wire logic                     we,
	input  wire logic [tes_pkg::IDX_W-1:0] widx,
	input  wire logic [1:0]               wfield,
	input  wire logic [31:0]              wdata,
	input  wire logic                     halve,
	input  wire logic [tes_pkg::IDX_W-1:0] ridx_a,
	input  wire logic [tes_pkg::IDX_W-1:0] ridx_b,
	output tes_pkg::tes_entry_t           ent_a,
	output tes_pkg::tes_entry_t           ent_b
);
	import tes_pkg::*;

	tes_entry_t ent_mem [NUM_ENT];

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_ENT; i++) begin
				ent_mem[i] <= ENT_RST;
			end
		end else if (ce) begin
			if (halve) begin
				for (int i = 0; i < NUM_ENT; i++) begin
					ent_mem[i].width  <= ent_mem[i].width >> 1;
					ent_mem[i].height <= ent_mem[i].height >> 1;
				end
			end else if (we && widx < NUM_ENT) begin
				case (wfield)
					FLD_ROI: begin
						ent_mem[widx].width  <= wdata[15:0];
						ent_mem[widx].height <= wdata[31:16];
					end
					FLD_OFS: begin
						ent_mem[widx].x <= wdata[15:0];
						ent_mem[widx].y <= wdata[31:16];
					end
					FLD_CFG: begin
						ent_mem[widx].fcount <= wdata[7:0];
						ent_mem[widx].next   <= wdata[11:8];
						ent_mem[widx].gain   <= wdata[31:16];
					end
					default: begin
						ent_mem[widx].exp_us <= wdata[EXP_W-1:0];
					end
				endcase
			end
		end
	end

	// Indices past the table read as the reset entry so a stray index cannot fault.
	assign ent_a = (ridx_a < NUM_ENT) ? ent_mem[ridx_a] : ENT_RST;
	assign ent_b = (ridx_b < NUM_ENT) ? ent_mem[ridx_b] : ENT_RST;

	a_halve_area: assert property (@(posedge mclk) disable iff (!rst_b)
		(halve && ce) |=> ent_mem[0].width == ($past(ent_mem[0].width) >> 1))
		else $error("Binning enable did not halve the stored width.");

endmodule : tes_entry_table

// File: tes_sequencer.sv
// Trigger and exposure sequencer top: register slave, double exposure and sequence trigger.
//
// Operation
// - first exposure from 10 us to 98.05 ms
// - exposure starts without line timing alignment
// - strobe one in exposure, two in readout
// - double exposure forces multi-frame, count two
// - double exposure forces trigger overlap off
// - start 6.1 us after trigger, gap 4.95 us
// - second exposure and readouts at most 98.05 ms
// - send selector picks normal, sequence or multi
// - ten entries, each with ROI, exposure, gain
// - each trigger captures current entry, then advances
// - table used only in sequence mode
// - per-entry frame count before moving on
// - per-entry next index field
// - entries reset to full-frame defaults, writable
// - repetition 1 to 255, zero means forever
// - binning on halves area, off leaves it; the code halves both width and height, leaving a quarter of the area
// - sequence mode allows no overlapped triggers
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module tes_sequencer #(
	parameter int TE_MAX_CYC = tes_pkg::TE_MAX_NS / tes_pkg::CLK_PERIOD_NS
) (
	input  wire logic          mclk,
	input  wire logic          rst_b,
	input  wire logic          ce,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output wire logic          hreadyout,
	output wire logic [31:0]   hrdata,
	output wire logic          hresp,
	input  wire logic          trig_in,
	output wire logic          exposure_active,
	output wire logic          readout_active,
	output wire logic          frame_start,
	output tes_pkg::tes_frame_t frame,
	output wire logic          stream_enable,
	output wire logic          strobe_window_1,
	output wire logic          strobe_window_2
);
	import tes_pkg::*;

	localparam int A_TD  = TD_CYC;
	localparam int A_ITF = ITF_CYC;

	logic             dph_r;
	logic [7:0]       addr_r;
	logic [31:0]      rdata_r;
	logic [31:0]      rd_mux;
	logic             wr_en;
	logic             wr_ctrl;
	logic             srst_p;
	logic             halve_p;
	logic             tbl_we;
	tes_vmode_t       mode_r;
	logic             piv_r;
	logic             ovl_r;
	logic             bin_r;
	logic             acq_multi_r;
	logic [7:0]       acq_cnt_r;
	logic [7:0]       rep_r;
	logic [CW-1:0]    exp1_r;
	logic [CW-1:0]    exp2_r;
	logic [CW-1:0]    rdlen_r;
	logic [IDX_W-1:0] sel_r;
	tes_state_t       st_r;
	tes_state_t       st_nxt;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic [CW-1:0]    rd_cnt_r;
	logic             rd_busy;
	logic             rd_start;
	logic             rd_first_r;
	logic             seq_step;
	logic             accept;
	logic             trig_p;
	logic [CW-1:0]    seq_exp;
	logic [IDX_W-1:0] cur_r;
	logic [IDX_W-1:0] nidx;
	logic [7:0]       fc_r;
	logic [7:0]       rdone_r;
	logic             sdone_r;
	logic             seq_last;
	logic             fstart_r;
	logic             stream_r;
	tes_entry_t       cur_ent;
	tes_entry_t       sel_ent;
	tes_frame_t       frame_r;
	tes_frame_t       seq_frame;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave. Wait states only while the clock enable freezes the block.
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;
	assign wr_en     = dph_r && ce;
	assign wr_ctrl   = wr_en && addr_r == OFS_CTRL;
	assign srst_p    = wr_ctrl && hwdata[CTRL_SRST];
	assign halve_p   = wr_ctrl && hwdata[CTRL_BIN] && !bin_r;
	assign tbl_we    = wr_en && addr_r[7:4] == OFS_ENT_ROI[7:4];

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dph_r  <= 1'b0;
			addr_r <= 8'h00;
		end else if (ce && hready) begin
			dph_r  <= hsel && htrans[1] && hwrite;
			addr_r <= haddr[7:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			OFS_CTRL: begin
				rd_mux[CTRL_MODE_LSB +: 2] = mode_r;
				rd_mux[CTRL_PIV]           = piv_r;
				rd_mux[CTRL_OVL]           = ovl_r;
				rd_mux[CTRL_BIN]           = bin_r;
			end
			OFS_ACQ: begin
				rd_mux[ACQ_MULTI]        = acq_multi_r;
				rd_mux[ACQ_CNT_LSB +: 8] = acq_cnt_r;
			end
			OFS_EXP1:    rd_mux[CW-1:0] = exp1_r;
			OFS_EXP2:    rd_mux[CW-1:0] = exp2_r;
			OFS_RDLEN:   rd_mux[CW-1:0] = rdlen_r;
			OFS_REP:     rd_mux[7:0] = rep_r;
			OFS_SEL:     rd_mux[IDX_W-1:0] = sel_r;
			OFS_STATUS: begin
				rd_mux[3:0]                  = st_r;
				rd_mux[STAT_IDX_LSB +: IDX_W] = cur_r;
				rd_mux[STAT_FC_LSB +: 8]     = fc_r;
				rd_mux[STAT_REP_LSB +: 8]    = rdone_r;
				rd_mux[STAT_DONE]            = sdone_r;
				rd_mux[STAT_RD]              = rd_busy;
			end
			OFS_ENT_ROI: rd_mux = {sel_ent.height, sel_ent.width};
			OFS_ENT_OFS: rd_mux = {sel_ent.y, sel_ent.x};
			OFS_ENT_CFG: rd_mux = {sel_ent.gain, 4'h0, sel_ent.next, sel_ent.fcount};
			OFS_ENT_EXP: rd_mux[EXP_W-1:0] = sel_ent.exp_us;
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 32'h0000_0000;
		end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
			rdata_r <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode and acquisition settings.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r      <= VM_NORMAL;
			piv_r       <= 1'b0;
			ovl_r       <= 1'b0;
			bin_r       <= 1'b0;
			acq_multi_r <= 1'b0;
			acq_cnt_r   <= ACQ_CNT_RST;
		end else if (ce) begin
			if (wr_ctrl) begin
				mode_r <= tes_vmode_t'(hwdata[CTRL_MODE_LSB +: 2]);
				piv_r  <= hwdata[CTRL_PIV];
				ovl_r  <= hwdata[CTRL_OVL] && !hwdata[CTRL_PIV];
				bin_r  <= hwdata[CTRL_BIN];
				if (hwdata[CTRL_PIV]) begin
					acq_multi_r <= 1'b1;
					acq_cnt_r   <= PIV_FRAMES;
				end
			end else if (wr_en && addr_r == OFS_ACQ) begin
				acq_multi_r <= piv_r || hwdata[ACQ_MULTI];
				acq_cnt_r   <= piv_r ? PIV_FRAMES : hwdata[ACQ_CNT_LSB +: 8];
			end
		end
	end

	// Durations are clamped on write, so software reads back what will be used.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			exp1_r  <= EXP1_RST;
			exp2_r  <= EXP2_RST;
			rdlen_r <= RDLEN_RST;
			rep_r   <= REP_RST;
			sel_r   <= '0;
		end else if (wr_en) begin
			case (addr_r)
				OFS_EXP1:  exp1_r  <= tes_clamp(hwdata, TE_MIN_CYC, TE_MAX_CYC);
				OFS_EXP2:  exp2_r  <= tes_clamp(hwdata, RD_MIN_CYC, TE_MAX_CYC);
				OFS_RDLEN: rdlen_r <= tes_clamp(hwdata, RD_MIN_CYC, TE_MAX_CYC);
				OFS_REP:   rep_r   <= hwdata[7:0];
				OFS_SEL:   sel_r   <= hwdata[IDX_W-1:0];
				default:   sel_r   <= sel_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	tes_trig_sync u_sync (
		.mclk (mclk),
		.rst_b(rst_b),
		.ce   (ce),
		.pin  (trig_in),
		.rise (trig_p)
	);

	tes_entry_table u_table (
		.mclk  (mclk),
		.rst_b (rst_b),
		.ce    (ce),
		.we    (tbl_we),
		.widx  (sel_r),
		.wfield(addr_r[3:2]),
		.wdata (hwdata),
		.halve (halve_p),
		.ridx_a(cur_r),
		.ridx_b(sel_r),
		.ent_a (cur_ent),
		.ent_b (sel_ent)
	);

	assign seq_exp   = tes_clamp(32'(cur_ent.exp_us) * CYC_PER_US, TE_MIN_CYC, TE_MAX_CYC);
	assign seq_frame = '{width: cur_ent.width, height: cur_ent.height, x: cur_ent.x,
		y: cur_ent.y, gain: cur_ent.gain};
	assign nidx      = (cur_ent.next < NUM_ENT) ? cur_ent.next : '0;

	////////////////////////////////////////////////////////////////////////////
	// Exposure sequencer. A trigger arriving during readout is dropped unless
	// overlap is on in a mode that allows it.
	assign rd_busy = rd_cnt_r != '0;
	assign accept  = (!rd_busy || (ovl_r && mode_r != VM_SEQ))
		&& !(mode_r == VM_SEQ && sdone_r && !piv_r);

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = (cnt_r != '0) ? cnt_r - 1'b1 : '0;
		rd_start = 1'b0;
		seq_step = 1'b0;
		case (st_r)
			ST_IDLE: begin
				// The delay counter starts the cycle after the synchronised trigger edge.
				if (trig_p && accept) begin
					if (piv_r) begin
						st_nxt  = ST_DELAY;
						cnt_nxt = CW'(TD_CYC - 1);
					end else begin
						st_nxt  = ST_EXP;
						cnt_nxt = ((mode_r == VM_SEQ) ? seq_exp : exp1_r) - 1'b1;
					end
				end
			end
			ST_DELAY: begin
				if (cnt_r == '0) begin
					st_nxt  = ST_EXP1;
					cnt_nxt = exp1_r - 1'b1;
				end
			end
			ST_EXP1: begin
				if (cnt_r == '0) begin
					st_nxt   = ST_GAP;
					cnt_nxt  = CW'(ITF_CYC - 1);
					rd_start = 1'b1;
				end
			end
			ST_GAP: begin
				if (cnt_r == '0) begin
					st_nxt  = ST_EXP2;
					cnt_nxt = exp2_r - 1'b1;
				end
			end
			ST_EXP2: begin
				if (cnt_r == '0) begin
					st_nxt = ST_WAIT_RD;
				end
			end
			ST_EXP: begin
				if (cnt_r == '0) begin
					st_nxt   = ST_WAIT_RD;
					seq_step = mode_r == VM_SEQ;
				end
			end
			ST_WAIT_RD: begin
				if (!rd_busy) begin
					st_nxt   = ST_IDLE;
					rd_start = 1'b1;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r  <= ST_IDLE;
			cnt_r <= '0;
		end else if (ce) begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_cnt_r   <= '0;
			rd_first_r <= 1'b0;
			fstart_r   <= 1'b0;
		end else if (ce) begin
			fstart_r <= rd_start;
			if (rd_start) begin
				rd_cnt_r   <= rdlen_r;
				rd_first_r <= st_r == ST_EXP1;
			end else if (rd_busy) begin
				rd_cnt_r <= rd_cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			frame_r  <= FRAME_DEF;
			stream_r <= 1'b1;
		end else if (ce) begin
			stream_r <= mode_r != VM_SEQ || !sdone_r;
			if (st_r == ST_IDLE && st_nxt != ST_IDLE) begin
				frame_r <= (mode_r == VM_SEQ && !piv_r) ? seq_frame : FRAME_DEF;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence position. A sequence pass ends when the walk returns to entry 0.
	// A pass that completes in the cycle of a sequence reset still reports done: the set wins.
	assign seq_last = seq_step && fc_r + 8'h01 >= cur_ent.fcount && nidx == '0
		&& rep_r != 8'h00 && rdone_r + 8'h01 == rep_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cur_r   <= '0;
			fc_r    <= 8'h00;
			rdone_r <= 8'h00;
			sdone_r <= 1'b0;
		end else if (ce) begin
			if (srst_p) begin
				cur_r   <= '0;
				fc_r    <= 8'h00;
				rdone_r <= 8'h00;
				sdone_r <= seq_last;
			end else if (seq_step) begin
				if (fc_r + 8'h01 >= cur_ent.fcount) begin
					fc_r  <= 8'h00;
					cur_r <= nidx;
					if (nidx == '0) begin
						rdone_r <= rdone_r + 8'h01;
						if (rep_r != 8'h00 && rdone_r + 8'h01 == rep_r) begin
							sdone_r <= 1'b1;
						end
					end
				end else begin
					fc_r <= fc_r + 8'h01;
				end
			end
		end
	end

	assign exposure_active = st_r == ST_EXP1 || st_r == ST_EXP2 || st_r == ST_EXP;
	assign readout_active  = rd_busy;
	assign frame_start     = fstart_r;
	assign frame           = frame_r;
	assign stream_enable   = stream_r;
	assign strobe_window_1 = st_r == ST_EXP1;
	assign strobe_window_2 = rd_first_r && rd_busy;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b || !ce);

	sequence s_enter_gap;
		$rose(st_r == ST_GAP);
	endsequence

	a_delay_time: assert property ($rose(st_r == ST_DELAY) |-> ##A_TD (st_r == ST_EXP1))
		else $error("First exposure did not start after the trigger delay.");
	a_gap_time: assert property (s_enter_gap |-> ##A_ITF (st_r == ST_EXP2))
		else $error("Second exposure did not start after the inter-frame gap.");
	a_exp1_range: assert property ($rose(st_r == ST_EXP1) |->
		cnt_r >= CW'(TE_MIN_CYC - 1) && cnt_r <= CW'(TE_MAX_CYC - 1))
		else $error("First exposure length out of range.");
	a_piv_ovl_off: assert property (piv_r |-> !ovl_r)
		else $error("Trigger overlap on in double exposure mode.");
	a_piv_frames: assert property (piv_r |-> acq_multi_r && acq_cnt_r == PIV_FRAMES)
		else $error("Double exposure mode not forced to two frames.");
	a_strobe_read: assert property (s_enter_gap |-> readout_active && strobe_window_2)
		else $error("First readout not running in the gap.");
	a_seq_no_ovl: assert property ((mode_r == VM_SEQ && rd_busy && st_r == ST_IDLE)
		|=> st_r == ST_IDLE)
		else $error("Sequence trigger accepted during readout.");
	a_seq_stop: assert property ((mode_r == VM_SEQ && !piv_r && sdone_r && !srst_p)
		|-> st_nxt != ST_DELAY && !(st_r == ST_IDLE && st_nxt == ST_EXP))
		else $error("Finished sequence responded to a trigger.");
	a_seq_frame: assert property ((st_r == ST_IDLE && st_nxt == ST_EXP && mode_r == VM_SEQ)
		|=> frame_r.width == $past(cur_ent.width) && frame_r.gain == $past(cur_ent.gain))
		else $error("Sequence frame does not carry the entry settings.");
	a_seq_advance: assert property ((seq_step && !srst_p && cur_ent.fcount == 8'h01)
		|=> cur_r == $past(nidx))
		else $error("Sequence did not advance to the next index.");
	a_normal_frame: assert property ((st_r == ST_IDLE && st_nxt == ST_EXP && mode_r != VM_SEQ)
		|=> frame_r == FRAME_DEF)
		else $error("Entry table applied outside sequence mode.");

endmodule : tes_sequencer

// File: tes_trig_src.sv
// Trigger source and strobe flash model facing the sequencer.
`timescale 1ns/1ps
module tes_trig_src #(
	parameter int MIN_GAP = 300,
	// The bench's sequence entries differ in exposure by this many cycles.
	parameter int EXP_DIFF = 50,
	parameter int RST_GAP = 500
) (
	input  wire logic mclk,
	input  wire logic go,
	input  wire logic seq_rst,
	input  wire logic strobe_window_1,
	input  wire logic strobe_window_2,
	output logic      trig_in,
	output int        flashes
);
	int   idle_n = 1000;
	int   need   = 0;
	logic pend   = 0;
	initial trig_in = 0;
	initial flashes = 0;
	// The pulse is held five clock cycles so the synchroniser cannot miss it.
	always @(posedge mclk) begin
		idle_n <= idle_n + 1;
		if (idle_n == 4)
			trig_in <= 0;
		if (go)
			pend <= 1;
		if (seq_rst) begin
			idle_n <= 0;
			need   <= RST_GAP;
		end else if (pend && idle_n >= need) begin
			trig_in <= 1;
			pend    <= 0;
			idle_n  <= 0;
			need    <= MIN_GAP + EXP_DIFF;
		end
		if ($rose(strobe_window_1) || $rose(strobe_window_2))
			flashes <= flashes + 1;
	end
endmodule : tes_trig_src

// File: testbench.sv
// Self-checking bench of the trigger and exposure sequencer.
`timescale 1ns/1ps
module testbench;
	import tes_pkg::*;
	localparam int TMAX = 2000;
	logic        mclk = 0;
	logic        rst_b = 0;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic        go = 0;
	logic        srst = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] rd, v, w0, w1, g0;
	logic [31:0] seed = 32'h14;
	wire logic [31:0] hrdata;
	wire logic   hreadyout, hresp, trig_in, exp_on, rd_on, fs, sen, sw1, sw2;
	tes_frame_t  frame;
	tes_frame_t  fr;
	int n_fail = 0;
	int n_tests = 0;
	int flashes, e_n, e_len, r_n, r_len, g_n, g_len, d_n, d_len, n_fs, rl, b;

	tes_sequencer #(.TE_MAX_CYC(TMAX)) u_tes_sequencer (.mclk(mclk), .rst_b(rst_b),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .trig_in(trig_in), .exposure_active(exp_on),
		.readout_active(rd_on), .frame_start(fs), .frame(frame), .stream_enable(sen),
		.strobe_window_1(sw1), .strobe_window_2(sw2));
	tes_trig_src u_tes_trig_src (.mclk(mclk), .go(go), .seq_rst(srst),
		.strobe_window_1(sw1), .strobe_window_2(sw2), .trig_in(trig_in), .flashes(flashes));

	always #50 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////////
	// Lengths are counted in sampled cycles so they match register counts.
	always @(posedge mclk) begin
		e_n <= exp_on ? e_n + 1 : 0;
		r_n <= rd_on ? r_n + 1 : 0;
		g_n <= exp_on ? 0 : g_n + 1;
		d_n <= $rose(trig_in) ? 1 : d_n + 1;
		if ($fell(exp_on))
			e_len <= e_n;
		if ($fell(rd_on))
			r_len <= r_n;
		if ($rose(exp_on))
			g_len <= g_n;
		if ($rose(sw1))
			d_len <= d_n;
		if (fs) begin
			n_fs <= n_fs + 1;
			fr   <= frame;
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic tes_frame_t fexp(input logic [31:0] roi, input logic [15:0] g);
		return '{width: roi[15:0], height: roi[31:16], x: 16'h0010, y: 16'h0004, gain: g};
	endfunction : fexp

	task automatic end_of_test();
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic ichk(input int got, input int exp);
		chk(80'(got), 80'(exp));
	endtask : ichk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(80'({hresp, rd}), 80'({1'b0, exp}));
	endtask : rchk

	// Fires one trigger and returns once the device has been quiet a while.
	task automatic shot();
		int t;
		int q;
		logic f;
		t = 0;
		q = 0;
		f = 0;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		while (q < 100 && t < 5000) begin
			@(posedge mclk);
			t++;
			f = f | trig_in;
			q = (!f || exp_on || rd_on) ? 0 : q + 1;
		end
	endtask : shot

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		chk(80'(frame), 80'(FRAME_DEF));
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_ACQ, 32'h100);
		rchk(OFS_EXP1, 32'h3e8);
		rchk(OFS_REP, 32'h1);
		rchk(8'hfc, 32'h0);
		for (int i = 0; i < NUM_ENT; i++) begin
			wr(OFS_SEL, 32'(i));
			rchk(OFS_ENT_ROI, 32'h09a80ce0);
			rchk(OFS_ENT_OFS, 32'h00040010);
			rchk(OFS_ENT_CFG, 32'h00000001);
			rchk(OFS_ENT_EXP, 32'h00017ed0);
		end
		wr(OFS_EXP1, 32'h5);
		rchk(OFS_EXP1, 32'h64);
		wr(OFS_EXP2, 32'hfffff);
		rchk(OFS_EXP2, 32'(TMAX));
		wr(OFS_RDLEN, 32'h0);
		rchk(OFS_RDLEN, 32'h1);
		rl = 20 + int'(rnd() % 64);
		wr(OFS_SEL, 32'h0);
		wr(OFS_ENT_ROI, rnd());
		wr(OFS_EXP1, 32'd150);
		wr(OFS_RDLEN, 32'(rl));
		shot();
		ichk(e_len, 150);
		ichk(r_len, rl);
		ichk(n_fs, 1);
		chk(80'(fr), 80'(FRAME_DEF));
		ichk(flashes, 0);
		wr(OFS_ACQ, 32'h0);
		wr(OFS_CTRL, 32'h0c);
		rchk(OFS_CTRL, 32'h04);
		rchk(OFS_ACQ, 32'h201);
		wr(OFS_ACQ, 32'h500);
		rchk(OFS_ACQ, 32'h201);
		wr(OFS_EXP1, 32'd100);
		wr(OFS_EXP2, 32'd120);
		wr(OFS_RDLEN, 32'd200);
		shot();
		ichk(g_len, ITF_CYC);
		ichk(int'(d_len >= TD_CYC && d_len <= TD_CYC + 6), 1);
		ichk(e_len, 120);
		ichk(r_len, 200);
		ichk(n_fs, 3);
		ichk(flashes, 2);
		wr(OFS_CTRL, 32'h0);
		v = rnd() & 32'h7ffe7ffe;
		wr(OFS_SEL, 32'h3);
		wr(OFS_ENT_ROI, v);
		wr(OFS_CTRL, 32'h10);
		rchk(OFS_ENT_ROI, v >> 1);
		wr(OFS_CTRL, 32'h0);
		rchk(OFS_ENT_ROI, v >> 1);
		w0 = rnd();
		w1 = rnd();
		g0 = rnd() & 32'hffff0000;
		wr(OFS_SEL, 32'h0);
		wr(OFS_ENT_ROI, w0);
		wr(OFS_ENT_CFG, g0 | 32'h102);
		wr(OFS_ENT_EXP, 32'd20);
		wr(OFS_SEL, 32'h1);
		wr(OFS_ENT_ROI, w1);
		wr(OFS_ENT_CFG, 32'h001);
		wr(OFS_ENT_EXP, 32'd15);
		wr(OFS_RDLEN, 32'd40);
		for (int r = 1; r >= 0; r--) begin
			wr(OFS_REP, 32'(r));
			wr(OFS_CTRL, 32'h29);
			srst <= 1'b1;
			@(posedge mclk);
			srst <= 1'b0;
			b = n_fs;
			for (int k = 0; k < 4; k++) begin
				shot();
				if (r == 1 && k == 3) begin
					ichk(n_fs, b + 3);
					chk(80'(sen), 80'h0);
					rchk(OFS_STATUS, 32'h01010000);
				end else begin
					chk(80'(fr), 80'(k == 2 ? fexp(w1, 16'h0) : fexp(w0, g0[31:16])));
					ichk(e_len, k == 2 ? 150 : 200);
				end
			end
		end
		chk(80'(sen), 80'h1);
		rchk(OFS_STATUS, 32'h00010100);
		wr(OFS_CTRL, 32'h2);
		rchk(OFS_CTRL, 32'h2);
		end_of_test();
	end

	initial begin
		#(100 * 60000);
		n_fail++;
		end_of_test();
	end
endmodule : testbench
